// [verilog/afspc_pkg.sv]
// Constants and types for the full-shutdown power control block
// Contract
// - Mode 11 written: power down at strobe rise
// - Shutdown entry puts track-and-hold into hold
// - Control register kept intact during shutdown
// - Shutdown persists until mode 00 is written
// - Mode 00 written: power up, track again
// - Busy output marks conversion in progress
// - Reset leaves mode field at normal 00
// - Write data captured at gated strobe rise
`default_nettype none
package afspc_pkg;
  localparam int CTRL_W = 12;
  localparam int PM_LO_POS = 0;
  localparam int PM_HI_POS = 1;
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_FULL_SHUTDOWN = 2'h3;
  localparam int CLK_HZ = 10000000;
  localparam int POWER_UP_MS = 10;
  localparam int POWER_UP_CYCLES = POWER_UP_MS * (CLK_HZ / 1000);
  localparam int CONV_CYCLES = 14;
  typedef enum logic [1:0] {
    AFSPC_IDLE = 2'b00,
    AFSPC_CONV = 2'b01,
    AFSPC_OFF = 2'b10
  } afspc_state_e;
endpackage : afspc_pkg
`default_nettype wire

// [verilog/afspc_top.sv]
// Full-shutdown power control, control register and busy logic
`default_nettype none
module afspc_top
  import afspc_pkg::*;
#(
  parameter int POWER_UP_CNT = POWER_UP_CYCLES,
  parameter int CONV_CNT = CONV_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Parallel bus write side
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic [11:0] data_in,
  // Conversion control
  input wire logic conversion_start_n,
  // Status outputs
  output logic [11:0] ctrl_out,
  output logic powered_down,
  output logic hold_mode,
  output logic power_up_pending,
  output logic dma_request_line,
  output logic conv_done
);
  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire logic srst_n = rst_s2_reg;

  logic strobe_reg;
  logic conv_in_reg;
  logic [11:0] ctrl_reg, ctrl_next;
  afspc_state_e state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [31:0] pu_reg, pu_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic hold_reg, hold_next;

  wire logic strobe = ~cs_n & ~wr_n;
  wire logic wr_rise = strobe_reg & ~strobe;
  wire logic conv_fall = conv_in_reg & ~conversion_start_n;
  wire logic [1:0] pm_wr = {data_in[PM_HI_POS], data_in[PM_LO_POS]};

  always_comb begin
    ctrl_next = ctrl_reg;
    state_next = state_reg;
    cnt_next = cnt_reg;
    pu_next = (pu_reg != 32'h0) ? pu_reg - 32'h1 : 32'h0;
    busy_next = busy_reg;
    done_next = 1'b0;
    hold_next = hold_reg;
    if (wr_rise) begin
      ctrl_next = data_in;
    end
    case (state_reg)
      AFSPC_IDLE: begin
        if (wr_rise && pm_wr == PM_FULL_SHUTDOWN) begin
          state_next = AFSPC_OFF;
          hold_next = 1'b1;
        end else if (conv_fall) begin
          state_next = AFSPC_CONV;
          cnt_next = 32'(CONV_CNT);
          busy_next = 1'b1;
          hold_next = 1'b1;
        end else if (!conversion_start_n) begin
          hold_next = hold_reg;
        end else begin
          hold_next = 1'b0;
        end
      end
      AFSPC_CONV: begin
        if (wr_rise && pm_wr == PM_FULL_SHUTDOWN) begin
          state_next = AFSPC_OFF;
          busy_next = 1'b0;
          hold_next = 1'b1;
        end else if (cnt_reg <= 32'h1) begin
          state_next = AFSPC_IDLE;
          busy_next = 1'b0;
          done_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 32'h1;
        end
      end
      AFSPC_OFF: begin
        hold_next = 1'b1;
        if (wr_rise && pm_wr == PM_NORMAL) begin
          state_next = AFSPC_IDLE;
          hold_next = 1'b0;
          pu_next = 32'(POWER_UP_CNT);
        end
      end
      default: begin
        state_next = AFSPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      strobe_reg <= 1'b0;
      conv_in_reg <= 1'b1;
      ctrl_reg <= CTRL_RESET;
      state_reg <= AFSPC_IDLE;
      cnt_reg <= 32'h0;
      pu_reg <= 32'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      hold_reg <= 1'b1;
    end else begin
      strobe_reg <= strobe;
      conv_in_reg <= conversion_start_n;
      ctrl_reg <= ctrl_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pu_reg <= pu_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      hold_reg <= hold_next;
    end
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      ctrl_out <= CTRL_RESET;
      powered_down <= 1'b0;
      hold_mode <= 1'b1;
      power_up_pending <= 1'b0;
      dma_request_line <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      ctrl_out <= ctrl_next;
      powered_down <= (state_next == AFSPC_OFF);
      hold_mode <= hold_next;
      power_up_pending <= (pu_next != 32'h0);
      dma_request_line <= busy_next;
      conv_done <= done_next;
    end
  end

  property p_shutdown_entry;
    @(posedge clk) disable iff (!srst_n)
    (state_reg != AFSPC_OFF && wr_rise && pm_wr == PM_FULL_SHUTDOWN)
      |=> (powered_down && hold_mode);
  endproperty
  a_shutdown_entry: assert property (p_shutdown_entry) else $error("no shutdown");

  property p_hold_during_off;
    @(posedge clk) disable iff (!srst_n)
    powered_down |-> hold_mode;
  endproperty
  a_hold_during_off: assert property (p_hold_during_off) else $error("track in shutdown");

  property p_ctrl_kept;
    @(posedge clk) disable iff (!srst_n)
    (powered_down && !wr_rise) |=> $stable(ctrl_out);
  endproperty
  a_ctrl_kept: assert property (p_ctrl_kept) else $error("ctrl lost");

  property p_stay_off;
    @(posedge clk) disable iff (!srst_n)
    (state_reg == AFSPC_OFF && !wr_rise) |=> powered_down;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("left shutdown");

  property p_wake;
    @(posedge clk) disable iff (!srst_n)
    (state_reg == AFSPC_OFF && wr_rise && pm_wr == PM_NORMAL)
      |=> (!powered_down && !hold_mode && power_up_pending);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  sequence s_start;
    state_reg == AFSPC_IDLE && conv_fall && !wr_rise;
  endsequence
  sequence s_busy;
    dma_request_line;
  endsequence
  property p_conv;
    @(posedge clk) disable iff (!srst_n)
    s_start |=> s_busy;
  endproperty
  a_conv: assert property (p_conv) else $error("busy missing");

  property p_done;
    @(posedge clk) disable iff (!srst_n)
    $fell(dma_request_line) && !powered_down |-> conv_done;
  endproperty
  a_done: assert property (p_done) else $error("done missing");

  property p_capture;
    @(posedge clk) disable iff (!srst_n)
    wr_rise |=> (ctrl_out == $past(data_in));
  endproperty
  a_capture: assert property (p_capture) else $error("bad capture");

  property p_abort;
    @(posedge clk) disable iff (!srst_n)
    (state_reg == AFSPC_CONV && wr_rise && pm_wr == PM_FULL_SHUTDOWN)
      |=> (!dma_request_line && !conv_done);
  endproperty
  a_abort: assert property (p_abort) else $error("conversion not aborted");

  property p_no_conv_off;
    @(posedge clk) disable iff (!srst_n)
    powered_down |-> (!dma_request_line && !conv_done);
  endproperty
  a_no_conv_off: assert property (p_no_conv_off) else $error("conversion in shutdown");

  property p_hold_conv;
    @(posedge clk) disable iff (!srst_n)
    dma_request_line |-> hold_mode;
  endproperty
  a_hold_conv: assert property (p_hold_conv) else $error("track during conversion");
endmodule : afspc_top
`default_nettype wire

// [verification/afspc_host.sv]
// Host model driving control writes and conversion starts
`default_nettype none
module afspc_host (
  // Clock
  input wire logic clk,
  // Bus and conversion drive
  output logic cs_n,
  output logic wr_n,
  output logic [11:0] data_in,
  output logic conversion_start_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    data_in = 12'h000;
    conversion_start_n = 1'b1;
  end
  task automatic write_word(input logic [11:0] w, input logic sel);
    @(posedge clk);
    cs_n <= ~sel;
    wr_n <= 1'b0;
    data_in <= w;
    @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    @(posedge clk);
    // Hold time is over, so the word no longer stands on the bus
    data_in <= ~w;
  endtask : write_word
  task automatic start_conv();
    @(posedge clk);
    conversion_start_n <= 1'b0;
    @(posedge clk);
    conversion_start_n <= 1'b1;
  endtask : start_conv
endmodule : afspc_host
`default_nettype wire

// [verification/tb_top.sv]
// Testbench for the full-shutdown power control block
`default_nettype none
`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); \
  end \
end
module tb_top
  import afspc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PU = 20;
  logic clk;
  logic rst_n;
  logic cs_n;
  logic wr_n;
  logic [11:0] data_in;
  logic conversion_start_n;
  logic [11:0] ctrl_out;
  logic powered_down, hold_mode, power_up_pending, dma_request_line, conv_done;
  int fail_count = 0;
  int check_count = 0;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  afspc_top #(.POWER_UP_CNT(PU), .CONV_CNT(CONV_CYCLES)) dut (.clk(clk), .rst_n(rst_n),
    .cs_n(cs_n), .wr_n(wr_n), .data_in(data_in), .conversion_start_n(conversion_start_n),
    .ctrl_out(ctrl_out), .powered_down(powered_down), .hold_mode(hold_mode),
    .power_up_pending(power_up_pending), .dma_request_line(dma_request_line),
    .conv_done(conv_done));
  afspc_host host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .data_in(data_in),
    .conversion_start_n(conversion_start_n));
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic check_state(input logic [11:0] c, input logic pd);
    @(posedge clk);
    #1;
    `CHK("ctrl_out", c, ctrl_out)
    `CHK("powered_down", pd, powered_down)
    `CHK("hold_mode", pd, hold_mode)
  endtask : check_state
  task automatic conv_ok();
    int n;
    host.start_conv();
    @(posedge clk);
    #1;
    `CHK("busy", 1'b1, dma_request_line)
    n = 1;
    while (conv_done !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("conv_len", CONV_CYCLES, n)
    `CHK("busy", 1'b0, dma_request_line)
  endtask : conv_ok
  task automatic abort_conv();
    int n;
    host.start_conv();
    #1;
    `CHK("busy", 1'b1, dma_request_line)
    host.write_word(12'h003, 1'b1);
    @(posedge clk);
    #1;
    `CHK("busy", 1'b0, dma_request_line)
    `CHK("powered_down", 1'b1, powered_down)
    `CHK("ctrl_out", 12'h003, ctrl_out)
    // An aborted conversion must never report completion
    n = 0;
    repeat (CONV_CYCLES) begin
      @(posedge clk);
      #1;
      if (conv_done === 1'b1) begin
        n++;
      end
    end
    `CHK("abort_done", 0, n)
  endtask : abort_conv
  task automatic reset_mid();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("ctrl_out", 12'h000, ctrl_out)
    `CHK("powered_down", 1'b0, powered_down)
    `CHK("hold_mode", 1'b1, hold_mode)
    `CHK("busy", 1'b0, dma_request_line)
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("ctrl_out", 12'h000, ctrl_out)
    `CHK("powered_down", 1'b0, powered_down)
  endtask : reset_mid
  initial begin
    int n;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("hold_mode", 1'b1, hold_mode)
    `CHK("ctrl_out", 12'h000, ctrl_out)
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    conv_ok();
    host.write_word(12'h003, 1'b0);
    check_state(12'h000, 1'b0);
    host.write_word(12'h5a7, 1'b1);
    check_state(12'h5a7, 1'b1);
    host.start_conv();
    repeat (CONV_CYCLES + 2) @(posedge clk);
    #1;
    `CHK("busy", 1'b0, dma_request_line)
    check_state(12'h5a7, 1'b1);
    host.write_word(12'h5a6, 1'b1);
    check_state(12'h5a6, 1'b1);
    host.write_word(12'h5a4, 1'b1);
    check_state(12'h5a4, 1'b0);
    // check_state samples the second pending cycle; n = 1 counts the first
    n = 1;
    while (power_up_pending === 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
      #1;
    end
    `CHK("power_up_len", PU, n)
    conv_ok();
    abort_conv();
    reset_mid();
    test_done();
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
